// ===== logic/timer16_pkg.sv
// Overview of operation
// - Bits 7, 6, 5 of control/status hold channel 2, 1, 0 pending flags.
// - Wrap flag bit 4 sets at terminal count, or at zero turnaround in up/down.
// - Two-bit divider field selects tick divide by 1, 8, 32 or 128.
// - Writing the divider field never clears the running prescaler counter.
// - Mode 00 suspends counting and holds the counter value.
// - Mode 01 counts from zero to 0xffff, wraps and repeats.
// - Mode 10 counts from zero to channel 0 compare value, then restarts.
// - Mode 11 counts up to the compare value, then down to zero, repeating.
// - Source bit 7 picks the capture pin or the masked radio events.
// - Channel 0 interrupt mask in bit 6 resets to one.
// - On match, codes 000, 001, 010 set, clear or toggle the output.
// - Code 011 sets on up match, clears at zero or on down match.
// - Code 100 clears on up match, sets at zero or on down match.
// - Setup bit 2 selects capture (0) or compare (1) for channel 0.
// - Edge code picks none, rising, falling or both edges for capture.
// - Any write to the counter low byte clears the whole counter.
// - Event flags set regardless of the channel interrupt mask.
// - Up/down compare mode sets channel 0 and wrap flags at zero turnaround.
`default_nettype none

package timer16_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMP0_LO = 8'hda;
    localparam logic [7:0] ADDR_CMP0_HI = 8'hdb;
    localparam logic [7:0] ADDR_CNT_LO = 8'he2;
    localparam logic [7:0] ADDR_CNT_HI = 8'he3;
    localparam logic [7:0] ADDR_CTRL = 8'he4;
    localparam logic [7:0] ADDR_CH0 = 8'he5;
    localparam logic [7:0] ADDR_RADIO_MASK = 8'he6;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_CH2F = 7;
    localparam int CTRL_CH1F = 6;
    localparam int CTRL_CH0F = 5;
    localparam int CTRL_WRAPF = 4;
    localparam int CTRL_DIV_LSB = 2;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CH0_SRC = 7;
    localparam int CH0_MASK = 6;
    localparam int CH0_ACT_LSB = 3;
    localparam int CH0_CMPMODE = 2;
    localparam int CH0_EDGE_LSB = 0;
    localparam logic [7:0] CH0_RESET = 8'h40;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // ----------------------------------------------------------------
    // Timing: prescaler divide ratios minus one
    // ----------------------------------------------------------------
    localparam logic [6:0] DIV1_LAST = 7'h00;
    localparam logic [6:0] DIV8_LAST = 7'h07;
    localparam logic [6:0] DIV32_LAST = 7'h1f;
    localparam logic [6:0] DIV128_LAST = 7'h7f;

    typedef enum logic [1:0] {
        MODE_SUSPEND = 2'b00,
        MODE_FREE = 2'b01,
        MODE_MODULO = 2'b10,
        MODE_UPDOWN = 2'b11
    } count_mode_t;

    typedef enum logic [2:0] {
        ACT_SET = 3'b000,
        ACT_CLEAR = 3'b001,
        ACT_TOGGLE = 3'b010,
        ACT_SET_UP = 3'b011,
        ACT_CLR_UP = 3'b100
    } out_action_t;
endpackage : timer16_pkg

`default_nettype wire

// ===== logic/timer16_ctrl_chan0.sv
// Local design decision: strobed register access.
`default_nettype none

module timer16_ctrl_chan0 (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tick_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic capture_pin,
    input wire logic [7:0] radio_events,
    input wire logic chan1_event,
    input wire logic chan2_event,
    output logic compare_out,
    output logic cpu_irq_flag,
    output logic [1:0] count_mode
);
    import timer16_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Register storage first, then the decoded conditions of this cycle.
    logic [7:0] timer_control_status;
    logic [7:0] chan0_setup;
    logic [7:0] radio_event_mask_reg;
    logic [15:0] counter;
    logic [15:0] period_compare_value;
    logic [7:0] count_hi_shadow;
    logic [6:0] prescale;
    logic count_down;
    logic capture_prev;
    logic [7:0] radio_prev;
    logic prescale_hit;
    logic step;
    logic at_top;
    logic at_match;
    logic turn_zero;
    logic wrap_event;
    logic chan0_event;
    logic capture_event;
    logic trig_rise;
    logic trig_fall;
    logic [15:0] next_counter;
    logic next_down;
    logic [1:0] div_sel;
    logic [2:0] act;
    logic cmp_mode;

    // Write strobe decode shared by all writable registers.
    // Reads are decoded in the read process, where the data is chosen.
    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // Field slices of the setup registers, named for what they steer.
    assign div_sel = timer_control_status[CTRL_DIV_LSB +: 2];
    assign act = chan0_setup[CH0_ACT_LSB +: 3];
    assign cmp_mode = chan0_setup[CH0_CMPMODE];

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // The prescaler keeps running across divider writes, so a new ratio
    // takes effect only once the counter passes its new terminal value.
    // Divide by 1 hits on every tick; the other ratios compare only the low bits that they need.
    always_comb begin
        case (div_sel)
            2'b00: prescale_hit = (prescale >= DIV1_LAST);
            2'b01: prescale_hit = (prescale[2:0] == DIV8_LAST[2:0]);
            2'b10: prescale_hit = (prescale[4:0] == DIV32_LAST[4:0]);
            default: prescale_hit = (prescale == DIV128_LAST);
        endcase
    end

    // The prescaler counts ticks, not clocks, so a slow tick source
    // stretches every ratio alike.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prescale <= 7'h00;
        end else if (tick_en) begin
            prescale <= prescale + 7'h01;
        end
    end

    // Suspend gates the step itself, so counter, wrap and compare flags and output
    // all freeze together and resume where they left off; captures still land.
    assign step = tick_en && prescale_hit && (count_mode != MODE_SUSPEND);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Terminal value: full range when free running, else the compare value.
    assign at_top = (count_mode == MODE_FREE) ? (counter == COUNT_MAX)
                                              : (counter == period_compare_value);
    // Match and turnaround are raw; users qualify them by the step.
    assign at_match = (counter == period_compare_value);
    assign turn_zero = (count_mode == MODE_UPDOWN) && count_down && (counter == 16'h0000);

    // Next value and direction for one step. A compare value of zero in
    // up/down mode parks the counter at zero instead of running through
    // the whole range.
    always_comb begin
        next_counter = counter;
        next_down = count_down;
        case (count_mode)
            MODE_FREE: begin
                next_counter = counter + 16'h0001;
                next_down = 1'b0;
            end
            MODE_MODULO: begin
                next_counter = at_top ? 16'h0000 : counter + 16'h0001;
                next_down = 1'b0;
            end
            MODE_UPDOWN: begin
                if (count_down && counter == 16'h0000) begin
                    next_down = 1'b0;
                    next_counter = 16'h0001;
                end else if (!count_down && at_top) begin
                    next_down = (counter != 16'h0000);
                    next_counter = (counter != 16'h0000) ? counter - 16'h0001 : counter;
                end else if (count_down) begin
                    next_counter = counter - 16'h0001;
                end else begin
                    next_counter = counter + 16'h0001;
                end
            end
            default: begin
                next_counter = counter;
            end
        endcase
    end

    // Writing the low byte zeroes the counter whatever value is written.
    // The clear also restarts the triangle on its rising side.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            counter <= 16'h0000;
            count_down <= 1'b0;
        end else if (wr_hit(ADDR_CNT_LO)) begin
            counter <= 16'h0000;
            count_down <= 1'b0;
        end else if (step) begin
            counter <= next_counter;
            count_down <= next_down;
        end
    end

    // ----------------------------------------------------------------
    // Capture trigger
    // ----------------------------------------------------------------
    // Radio events are edge detected per bit and then masked.
    // The previous samples load the live inputs in reset, so a line that
    // idles high is not taken for an edge on the first clock after it.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            capture_prev <= capture_pin;
            radio_prev <= radio_events;
        end else begin
            capture_prev <= capture_pin;
            radio_prev <= radio_events;
        end
    end

    // Source select, then the edge filter; compare mode blocks capture
    // so a stray edge cannot overwrite the compare value.
    always_comb begin
        if (chan0_setup[CH0_SRC]) begin
            trig_rise = |(radio_events & ~radio_prev & radio_event_mask_reg);
            trig_fall = |(~radio_events & radio_prev & radio_event_mask_reg);
        end else begin
            trig_rise = capture_pin && !capture_prev;
            trig_fall = !capture_pin && capture_prev;
        end
        case (chan0_setup[CH0_EDGE_LSB +: 2])
            2'b01: capture_event = trig_rise;
            2'b10: capture_event = trig_fall;
            2'b11: capture_event = trig_rise || trig_fall;
            default: capture_event = 1'b0;
        endcase
        capture_event = capture_event && !cmp_mode;
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    // Wrap and compare events are qualified by the counting step so each match fires once.
    // In up/down compare mode channel 0 marks the turn at zero instead.
    assign wrap_event = step && (((count_mode != MODE_UPDOWN) && at_top) || turn_zero);
    // The channel 0 event follows the channel's capture or compare role.
    always_comb begin
        if (!cmp_mode) begin
            chan0_event = capture_event;
        end else if (count_mode == MODE_UPDOWN) begin
            chan0_event = step && turn_zero;
        end else begin
            chan0_event = step && at_match;
        end
    end

    // ----------------------------------------------------------------
    // Channel 0 value register and capture latch
    // ----------------------------------------------------------------
    // The capture latch shares its register with the compare value.
    // A capture beats a same-cycle software write, so a captured time
    // is never lost; the byte write is dropped instead.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            period_compare_value <= 16'h0000;
        end else if (capture_event) begin
            period_compare_value <= counter;
        end else if (wr_hit(ADDR_CMP0_LO)) begin
            period_compare_value[7:0] <= reg_wdata;
        end else if (wr_hit(ADDR_CMP0_HI)) begin
            period_compare_value[15:8] <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Control and setup registers
    // ----------------------------------------------------------------
    // Flags take software zeros, but a hardware set in the same cycle wins.
    // Ones leave a flag alone, so software clears one flag without
    // racing the others.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            timer_control_status <= CTRL_RESET;
        end else begin
            if (wr_hit(ADDR_CTRL)) begin
                timer_control_status[3:0] <= reg_wdata[3:0];
                timer_control_status[7:4] <= timer_control_status[7:4] & reg_wdata[7:4];
            end
            if (chan2_event) begin
                timer_control_status[CTRL_CH2F] <= 1'b1;
            end
            if (chan1_event) begin
                timer_control_status[CTRL_CH1F] <= 1'b1;
            end
            if (chan0_event) begin
                timer_control_status[CTRL_CH0F] <= 1'b1;
            end
            if (wrap_event) begin
                timer_control_status[CTRL_WRAPF] <= 1'b1;
            end
        end
    end

    // Setup and radio mask are plain storage; reserved compare codes
    // are stored as written and act on nothing.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            chan0_setup <= CH0_RESET;
            radio_event_mask_reg <= 8'h00;
        end else begin
            if (wr_hit(ADDR_CH0)) begin
                chan0_setup <= reg_wdata;
            end
            if (wr_hit(ADDR_RADIO_MASK)) begin
                radio_event_mask_reg <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Compare output
    // ----------------------------------------------------------------
    // Reserved action codes leave the pin unchanged.
    // Actions happen only on steps, so a stalled counter sitting on
    // its match cannot toggle the pin on every clock.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            compare_out <= 1'b0;
        end else if (step && cmp_mode) begin
            case (act)
                ACT_SET: if (at_match) compare_out <= 1'b1;
                ACT_CLEAR: if (at_match) compare_out <= 1'b0;
                ACT_TOGGLE: if (at_match) compare_out <= !compare_out;
                ACT_SET_UP: begin
                    if (at_match && !count_down) begin
                        compare_out <= 1'b1;
                    end else if (count_mode == MODE_UPDOWN ? (at_match && count_down)
                                                             : (counter == 16'h0000)) begin
                        compare_out <= 1'b0;
                    end
                end
                ACT_CLR_UP: begin
                    if (at_match && !count_down) begin
                        compare_out <= 1'b0;
                    end else if (count_mode == MODE_UPDOWN ? (at_match && count_down)
                                                             : (counter == 16'h0000)) begin
                        compare_out <= 1'b1;
                    end
                end
                default: compare_out <= compare_out;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read port and registered outputs
    // ----------------------------------------------------------------
    // Reading the low byte freezes the high byte so a 16-bit read is coherent.
    // Idle cycles and unmapped addresses read as zero, so stale data
    // never lingers on the bus.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            count_hi_shadow <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CNT_LO: begin
                    reg_rdata <= counter[7:0];
                    count_hi_shadow <= counter[15:8];
                end
                ADDR_CNT_HI: reg_rdata <= count_hi_shadow;
                ADDR_CTRL: reg_rdata <= timer_control_status;
                ADDR_CH0: reg_rdata <= chan0_setup;
                ADDR_CMP0_LO: reg_rdata <= period_compare_value[7:0];
                ADDR_CMP0_HI: reg_rdata <= period_compare_value[15:8];
                ADDR_RADIO_MASK: reg_rdata <= radio_event_mask_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Only the processor-level flag looks at the mask.
    // The counter steers by the mode copy, so a mode write takes
    // effect one clock after it lands.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cpu_irq_flag <= 1'b0;
            count_mode <= MODE_SUSPEND;
        end else begin
            cpu_irq_flag <= timer_control_status[CTRL_CH0F] && chan0_setup[CH0_MASK];
            count_mode <= timer_control_status[CTRL_MODE_LSB +: 2];
        end
    end
endmodule // timer16_ctrl_chan0

`default_nettype wire

// ===== testbench/timer16_ctrl_chan0_properties.sv
`default_nettype none

module timer16_ctrl_chan0_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic chan1_event,
    input wire logic chan2_event,
    input wire logic cpu_irq_flag,
    input wire logic [1:0] count_mode
);
    import timer16_pkg::*;
    // Decoded strobes keep the properties short; they hold no state.
    wire logic wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
    wire logic rd_ctrl = reg_rd && reg_addr == ADDR_CTRL;
    wire logic wr_ch0 = reg_wr && reg_addr == ADDR_CH0;
    wire logic [1:0] wmode = reg_wdata[1:0];
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_chan1_flag: assert property (chan1_event ##1 rd_ctrl |=> reg_rdata[6])
        else $error("channel 1 event did not set its flag");
    a_chan2_flag: assert property (chan2_event ##1 rd_ctrl |=> reg_rdata[7])
        else $error("channel 2 event did not set its flag");
    a_flag_clear: assert property (wr_ctrl && !reg_wdata[7] && !chan2_event ##1
        rd_ctrl && !chan2_event |=> !reg_rdata[7])
        else $error("writing zero did not clear the flag");
    a_mask_blocks: assert property (wr_ch0 && !reg_wdata[6] ##1 !wr_ch0 |=> !cpu_irq_flag)
        else $error("masked channel still raised the cpu flag");
    a_setup_back: assert property (wr_ch0 ##1 reg_rd && reg_addr == ADDR_CH0 |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("setup register read back wrong");
    a_mode_copy: assert property (wr_ctrl |=> ##1 count_mode == $past(wmode, 2))
        else $error("mode output does not follow the mode field");
    a_count_clear: assert property (reg_wr && reg_addr == ADDR_CNT_LO ##1
        reg_rd && reg_addr == ADDR_CNT_LO |=> reg_rdata == 8'h00)
        else $error("counter not cleared by low byte write");
endmodule // timer16_ctrl_chan0_properties

bind timer16_ctrl_chan0 timer16_ctrl_chan0_properties chk_u (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan1_event(chan1_event),
    .chan2_event(chan2_event), .cpu_irq_flag(cpu_irq_flag), .count_mode(count_mode)
);

`default_nettype wire

// ===== testbench/pin_partner.sv
`default_nettype none

module pin_partner (
    input wire logic mclk,
    input wire logic level_req,
    input wire logic [3:0] lag,
    input wire logic watch,
    input wire logic compare_out,
    output logic capture_pin,
    output logic [7:0] ones
);
    logic [7:0] hist = 8'h00;
    // The pin follows the request after lag plus one edges, so slow sources are covered too.
    always @(posedge mclk) begin
        hist <= {hist[6:0], level_req};
    end
    assign capture_pin = hist[lag[2:0]];
    // High samples of the output are counted only while watched.
    always @(posedge mclk) begin
        ones <= watch ? ones + {7'h00, compare_out} : 8'h00;
    end
endmodule // pin_partner

`default_nettype wire

// ===== testbench/timer16_ctrl_chan0_tb.sv
`default_nettype none

module timer16_ctrl_chan0_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import timer16_pkg::*;

    typedef struct packed {
        logic w;
        logic r;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    // Plain register cases: strobes, address, data, expected read value.
    localparam row_t ROWS [10] = '{
        '{1'b0, 1'b1, ADDR_CH0, 8'h00, CH0_RESET},
        '{1'b0, 1'b1, ADDR_CTRL, 8'h00, CTRL_RESET},
        '{1'b1, 1'b0, ADDR_CH0, 8'h9d, 8'h00},
        '{1'b0, 1'b1, ADDR_CH0, 8'h00, 8'h9d},
        '{1'b1, 1'b0, 8'h00, 8'hff, 8'h00},
        '{1'b0, 1'b1, 8'h00, 8'h00, 8'h00},
        '{1'b1, 1'b0, ADDR_CNT_LO, 8'h5a, 8'h00},
        '{1'b0, 1'b1, ADDR_CNT_LO, 8'h00, 8'h00},
        '{1'b1, 1'b0, ADDR_RADIO_MASK, 8'h01, 8'h00},
        '{1'b0, 1'b1, ADDR_RADIO_MASK, 8'h00, 8'h01}
    };
    logic mclk = 1'b0, resetn = 1'b0, tick_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic chan1_event = 1'b0, chan2_event = 1'b0, level_req = 1'b0, watch = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, radio_events = 8'h00;
    logic [7:0] reg_rdata, ones, q, first, prev, step;
    logic [7:0] exp_ones [5] = '{8'h10, 8'h00, 8'h08, 8'h04, 8'h0c};
    logic [3:0] lag = 4'h0;
    logic compare_out, cpu_irq_flag, capture_pin;
    logic [1:0] count_mode;
    int fail_count = 0, n_tests = 0, span;

    timer16_ctrl_chan0 dut_u (
        .mclk(mclk), .resetn(resetn), .tick_en(tick_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capture_pin(capture_pin), .radio_events(radio_events), .chan1_event(chan1_event),
        .chan2_event(chan2_event), .compare_out(compare_out), .cpu_irq_flag(cpu_irq_flag),
        .count_mode(count_mode)
    );
    pin_partner pin_u (
        .mclk(mclk), .level_req(level_req), .lag(lag), .watch(watch),
        .compare_out(compare_out), .capture_pin(capture_pin), .ones(ones)
    );

    always #20 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Bus, compare and closing tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle; strobes stay as driven until the next call, so no gap is forced.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        #1 q = reg_rdata;
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // Pin and radio line move in opposite directions, so a wrong source shows up.
    task automatic edge_try(input logic up, input logic expect_flag);
        level_req <= up;
        radio_events <= {7'h00, !up};
        wait_cycles(12);
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check({7'h00, q[5]}, {7'h00, expect_flag});
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The full run takes about 67300 cycles; the limit leaves a margin.
    initial begin
        repeat (90000) @(posedge mclk);
        fail_count++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        foreach (ROWS[i]) begin
            bus(ROWS[i].w, ROWS[i].r, ROWS[i].a, ROWS[i].d);
            if (ROWS[i].r) check(q, ROWS[i].e);
        end
        chan1_event <= 1'b1;
        chan2_event <= 1'b1;
        wait_cycles(1);
        chan1_event <= 1'b0;
        chan2_event <= 1'b0;
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check(q & 8'hc0, 8'hc0);
        chan1_event <= 1'b1;
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
        chan1_event <= 1'b0;
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check(q & 8'hc0, 8'h40);
        // Spans are whole prescaler periods, so the step count is phase free.
        for (int k = 0; k < 4; k++) begin
            span = (k == 0) ? 1 : (8 << (2 * k - 2));
            bus(1'b1, 1'b0, ADDR_CTRL, {4'h0, k[1:0], 2'b01});
            wait_cycles(span);
            bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
            first = q;
            wait_cycles(4 * span - 1);
            bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
            check(q - first, 8'h04);
        end
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
        // The counter steers by the mode copy, so one more step follows the write.
        wait_cycles(1);
        bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
        first = q;
        wait_cycles(20);
        bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
        check(q, first);
        bus(1'b1, 1'b0, ADDR_CMP0_LO, 8'h03);
        bus(1'b1, 1'b0, ADDR_CMP0_HI, 8'h00);
        bus(1'b1, 1'b0, ADDR_CH0, 8'h44);
        for (int m = 2; m < 4; m++) begin
            bus(1'b1, 1'b0, ADDR_CNT_LO, 8'h00);
            bus(1'b1, 1'b0, ADDR_CTRL, {6'h00, m[1:0]});
            wait_cycles(2);
            bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
            for (int i = 0; i < 8; i++) begin
                prev = q;
                bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
                step = q - prev;
                if (m == 2) check(q, (prev + 8'h01) & 8'h03);
                else check({7'h00, q < 8'h04 && (step == 8'h01 || step == 8'hff)}, 8'h01);
            end
            bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
            check(q & 8'h30, 8'h30);
        end
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h02);
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, 1'b0, ADDR_CH0, {2'b01, c[2:0], 3'b100});
            wait_cycles(8);
            watch <= 1'b1;
            wait_cycles(16);
            watch <= 1'b0;
            check(ones, exp_ones[c]);
        end
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
        radio_events <= 8'h01;
        for (int c = 0; c < 8; c++) begin
            lag <= c[3:0];
            bus(1'b1, 1'b0, ADDR_CH0, {c[2], 5'h00, c[1:0]});
            wait_cycles(3);
            bus(1'b1, 1'b0, ADDR_CTRL, 8'h00);
            edge_try(1'b1, c[2] ? c[1] : c[0]);
            edge_try(1'b0, c[2] ? c[0] : c[1]);
        end
        bus(1'b1, 1'b0, ADDR_CH0, 8'h43);
        level_req <= 1'b1;
        wait_cycles(12);
        check({7'h00, cpu_irq_flag}, 8'h01);
        bus(1'b1, 1'b0, ADDR_CH0, 8'h03);
        wait_cycles(2);
        check({7'h00, cpu_irq_flag}, 8'h00);
        bus(1'b1, 1'b0, ADDR_CNT_LO, 8'h00);
        bus(1'b1, 1'b0, ADDR_CTRL, 8'h01);
        wait_cycles(65000);
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check(q & 8'h10, 8'h00);
        wait_cycles(1000);
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check(q & 8'h10, 8'h10);
        check({6'h00, count_mode}, 8'h01);
        // With the tick enable held low the counter must stand still.
        tick_en <= 1'b0;
        bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
        first = q;
        wait_cycles(5);
        bus(1'b0, 1'b1, ADDR_CNT_LO, 8'h00);
        check(q, first);
        tick_en <= 1'b1;
        // A reset in mid-run brings registers and outputs back to reset values.
        resetn <= 1'b0;
        wait_cycles(2);
        resetn <= 1'b1;
        check({6'h00, count_mode}, 8'h00);
        check({6'h00, compare_out, cpu_irq_flag}, 8'h00);
        bus(1'b0, 1'b1, ADDR_CH0, 8'h00);
        check(q, CH0_RESET);
        bus(1'b0, 1'b1, ADDR_CTRL, 8'h00);
        check(q, CTRL_RESET);
        final_report();
    end
endmodule // timer16_ctrl_chan0_tb

`default_nettype wire
